/* quad_retime_buf.sv */
// Top of the four-channel buffer with selectable retiming
`timescale 1ns/1ps
module quad_retime_buf #(
  parameter int unsigned W = retime_pkg::CH_COUNT
) (
  input wire logic ref_clk_in, // System clock, 50 MHz
  input wire logic arst_n_in, // Async reset, active low
  input wire logic [W-1:0] data_in, // Channel inputs
  input wire logic ext_clk_in, // Shared retiming clock, sampled
  input wire logic mode_sel_in, // High async, low sync
  input wire logic out_en_in, // High enables outputs
  output logic [W-1:0] data_out // Channel outputs
);
  import retime_pkg::*;

  typedef struct packed {
    logic clk_prev_reg;
  } ctrl_state_t;

  ctrl_state_t st_reg;
  ctrl_state_t st_next;
  logic clk_rise;
  logic enabled;
  logic sync_mode;

  cap_if #(.W(W)) cap ();

  capture_bank #(.W(W)) u_bank (
    .ref_clk_in(ref_clk_in),
    .cap(cap)
  );

  always_comb begin
    st_next = st_reg;
    st_next.clk_prev_reg = ext_clk_in;
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_reg.clk_prev_reg <= CLK_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign enabled = (out_en_in == EN_ON);
  assign sync_mode = (mode_sel_in == MODE_SYNC);
  // Edge tracking runs even when disabled so a level held
  // through the disable window is not mistaken for an edge
  assign clk_rise = ext_clk_in & ~st_reg.clk_prev_reg;

  assign cap.d = data_in;
  // capture on rise in sync mode
  assign cap.load = enabled & sync_mode & clk_rise;

  always_comb begin
    if (!enabled) begin
      data_out = {W{OUT_OFF}};
    end else if (sync_mode) begin
      data_out = cap.q;
    end else begin
      data_out = data_in;
    end
  end

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!arst_n_in);

  sync_capture_a: assert property (
    cap.load |=> cap.q == $past(data_in))
    else $error("Captured value differs from sampled input");

  async_pass_a: assert property (
    enabled && !sync_mode |-> data_out == data_in)
    else $error("Async output does not follow input");

  async_noclk_a: assert property (
    !sync_mode ##1 !sync_mode |-> cap.q === $past(cap.q))
    else $error("Clock changed capture in async mode");

  sync_out_a: assert property (
    enabled && sync_mode |-> data_out === cap.q)
    else $error("Sync output not driven from capture");

  disable_low_a: assert property (
    !enabled |-> data_out == {W{OUT_OFF}})
    else $error("Disabled output not low");

  ignore_dis_a: assert property (
    !enabled ##1 !enabled |-> cap.q === $past(cap.q))
    else $error("Capture changed while disabled");

  hold_cap_a: assert property (
    !cap.load |=> cap.q === $past(cap.q))
    else $error("Capture changed without a load");

  rise_load_a: assert property (
    enabled && sync_mode && !st_reg.clk_prev_reg && ext_clk_in |-> cap.load)
    else $error("Rising clock edge missed in sync mode");

  async_no_load_a: assert property (
    !sync_mode |-> !cap.load)
    else $error("Capture loaded in async mode");

  off_no_load_a: assert property (
    !enabled |-> !cap.load)
    else $error("Capture loaded while disabled");

  // Checked against the raw pin history, not the edge tracker
  edge_load_a: assert property (
    $past(arst_n_in) && enabled && sync_mode && ext_clk_in && !$past(ext_clk_in)
      |-> cap.load)
    else $error("Sampled clock rise not captured");

  // First cycle after reset excluded: the tracker restarts low, so a pin already high counts as a rise
  level_no_load_a: assert property (
    $past(arst_n_in) && $past(ext_clk_in) |-> !cap.load)
    else $error("Capture on a level, not a rise");

  one_load_a: assert property (
    cap.load |=> !cap.load)
    else $error("Two captures from one clock rise");

  tracker_a: assert property (
    $past(arst_n_in) |-> st_reg.clk_prev_reg == $past(ext_clk_in))
    else $error("Edge tracker lost the clock pin");

  off_stable_a: assert property (
    !enabled ##1 !enabled |-> data_out == $past(data_out))
    else $error("Disabled output moved");

  reenable_hold_a: assert property (
    !enabled ##1 enabled && sync_mode |-> data_out === $past(cap.q))
    else $error("Re-enabled output lost held capture");

  hold_out_a: assert property (
    enabled && sync_mode && !cap.load ##1 enabled && sync_mode
      |-> data_out === $past(data_out))
    else $error("Sync output moved without a capture");

  async_follow_a: assert property (
    enabled && !sync_mode ##1 enabled && !sync_mode && $changed(data_in)
      |-> $changed(data_out))
    else $error("Async output missed an input change");

  // Mode changes reach the outputs in the same cycle
  to_async_a: assert property (
    enabled && sync_mode ##1 enabled && !sync_mode |-> data_out == data_in)
    else $error("Output not switched to pass-through");

  to_sync_a: assert property (
    enabled && !sync_mode ##1 enabled && sync_mode |-> data_out === $past(cap.q))
    else $error("Output not switched to held capture");

  on_async_a: assert property (
    !enabled ##1 enabled && !sync_mode |-> data_out == data_in)
    else $error("Re-enabled async output not following input");

  genvar ch;
  // Lane-by-lane view so a stuck channel is named by its index
  generate
    for (ch = 0; ch < W; ch++) begin : g_lane_chk
      lane_pass_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
        enabled && !sync_mode |-> data_out[ch] == data_in[ch])
        else $error("Lane output does not follow its input");

      lane_low_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
        !enabled |-> data_out[ch] == OUT_OFF)
        else $error("Lane output not low while disabled");

      lane_cap_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
        cap.load |=> cap.q[ch] == $past(data_in[ch]))
        else $error("Lane captured a wrong value");

      lane_sync_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
        enabled && sync_mode |-> data_out[ch] === cap.q[ch])
        else $error("Lane output not taken from its capture");

      lane_hold_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
        !cap.load |=> cap.q[ch] === $past(cap.q[ch]))
        else $error("Lane capture changed without a load");

      lane_ignore_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
        !enabled ##1 !enabled |-> cap.q[ch] === $past(cap.q[ch]))
        else $error("Lane capture changed while disabled");

      lane_noclk_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
        !sync_mode ##1 !sync_mode |-> cap.q[ch] === $past(cap.q[ch]))
        else $error("Lane capture changed in async mode");
    end
  endgenerate

  sync_run_c: cover property (cap.load ##1 enabled && sync_mode);
  async_run_c: cover property (enabled && !sync_mode ##1 data_out != $past(data_out));
  reenable_c: cover property (!enabled ##1 enabled && sync_mode);
  off_rise_c: cover property (!enabled && clk_rise);
  async_rise_c: cover property (enabled && !sync_mode && clk_rise);
endmodule

/* retime_pkg.sv */
// Shared constants for the quad selectable retiming buffer
// Overview of operation
// - Select high: each channel passes straight through
// - Select low: all channels captured on clock rise
// - Enabled outputs follow the selected channel path
// - Disabled outputs are forced low
// - Disabled: clock, select and inputs ignored
package retime_pkg;
  localparam int unsigned CH_COUNT = 4;
  localparam logic MODE_ASYNC = 1'h1;
  localparam logic MODE_SYNC = 1'h0;
  localparam logic EN_ON = 1'h1;
  localparam logic CLK_IDLE = 1'h0;
  localparam logic OUT_OFF = 1'h0;
endpackage

/* cap_if.sv */
// Carrier between the control logic and the capture bank
`timescale 1ns/1ps
interface cap_if #(
  parameter int unsigned W = retime_pkg::CH_COUNT
);
  logic [W-1:0] d;
  logic load;
  logic [W-1:0] q;
  modport ctrl (output d, output load, input q);
  modport bank (input d, input load, output q);
endinterface

/* capture_bank.sv */
// Per-channel capture flip-flops of the synchronous path
`timescale 1ns/1ps
module capture_bank #(
  parameter int unsigned W = retime_pkg::CH_COUNT
) (
  input wire logic ref_clk_in, // System clock
  cap_if.bank cap // Data, load strobe and captured value
);
  import retime_pkg::*;

  typedef struct packed {
    logic [W-1:0] q_reg;
  } bank_state_t;

  bank_state_t st_reg;
  bank_state_t st_next;
  logic [W-1:0] q_next;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_ch
      assign q_next[i] = cap.load ? cap.d[i] : st_reg.q_reg[i];
    end
  endgenerate

  always_comb begin
    st_next = st_reg;
    st_next.q_reg = q_next;
  end

  // No reset on purpose: values persist as a plain latch bank would
  always_ff @(posedge ref_clk_in) begin
    st_reg <= st_next;
  end

  assign cap.q = st_reg.q_reg;
endmodule

/* ext_clk_src.sv */
// Model of the external retiming clock source
`timescale 1ns/1ps
module ext_clk_src (
  input wire logic ref_clk_in, // Bench clock
  input wire logic tick_in, // Request one rise
  output logic clk_out // Retiming clock
);
  initial clk_out = 1'h0;
  always @(posedge ref_clk_in) clk_out <= #1 tick_in;
endmodule

/* tb.sv */
// Self-checking bench for the quad retiming buffer
`timescale 1ns/1ps
module tb;
  import retime_pkg::*;
  logic ref_clk_in = 1'h0;
  logic arst_n_in = 1'h0;
  logic [3:0] data_in = 4'h0;
  logic tick = 1'h0;
  logic ext_clk;
  logic mode_sel_in = MODE_ASYNC;
  logic out_en_in = EN_ON;
  logic [3:0] data_out;
  int mismatches = 0;
  int tests_run = 0;
  quad_retime_buf uut (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .data_in(data_in),
    .ext_clk_in(ext_clk), .mode_sel_in(mode_sel_in), .out_en_in(out_en_in),
    .data_out(data_out));
  ext_clk_src src (.ref_clk_in(ref_clk_in), .tick_in(tick), .clk_out(ext_clk));
  initial forever #10 ref_clk_in = ~ref_clk_in;
  task automatic step;
    @(posedge ref_clk_in);
    #1;
  endtask
  task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Data held through the sampled rise
  task automatic rise(input logic [3:0] v);
    data_in = v;
    tick = 1'h1;
    step;
    tick = 1'h0;
    step;
  endtask
  task automatic pass_through;
    data_in = 4'hA;
    step;
    check("async", data_out, 4'hA);
    rise(4'h5);
    check("async clk", data_out, 4'h5);
  endtask
  task automatic retime;
    mode_sel_in = MODE_SYNC;
    rise(4'h6);
    check("capture", data_out, 4'h6);
    data_in = 4'h9;
    step;
    check("hold", data_out, 4'h6);
    mode_sel_in = MODE_ASYNC;
    step;
    check("to async", data_out, 4'h9);
    mode_sel_in = MODE_SYNC;
    step;
    check("to sync", data_out, 4'h6);
  endtask
  task automatic disabled;
    out_en_in = 1'h0;
    step;
    check("off", data_out, 4'h0);
    rise(4'hC);
    check("off clk", data_out, 4'h0);
    mode_sel_in = MODE_ASYNC;
    step;
    check("off async", data_out, 4'h0);
    mode_sel_in = MODE_SYNC;
    out_en_in = EN_ON;
    step;
    check("reenable", data_out, 4'h6);
    rise(4'h3);
    check("next rise", data_out, 4'h3);
  endtask
  // Clock held high: only its first sampled rise captures
  task automatic held_clock;
    data_in = 4'hB;
    tick = 1'h1;
    step;
    step;
    data_in = 4'hD;
    step;
    tick = 1'h0;
    step;
    check("held high", data_out, 4'hB);
  endtask
  task automatic complete_run;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge ref_clk_in);
    #1 arst_n_in = 1'h1;
    step;
    pass_through;
    retime;
    disabled;
    held_clock;
    complete_run;
  end
  // Run needs under 50 cycles; wide margin
  initial begin
    #100000;
    mismatches++;
    complete_run;
  end
endmodule
